// file: core_regs_pkg.sv
// Purpose: Shared constants and types for the core register set.
// Assumes: 8-bit data path, 16-bit program counter, single core clock.
// Notes: Flag bit positions and reset values live here so every file agrees.
package core_regs_pkg;

  // ----------------------------------------------------------------
  // Flag field positions
  // ----------------------------------------------------------------
  localparam int unsigned FLAG_IE_POS = 0;
  localparam int unsigned FLAG_ZERO_POS = 1;
  localparam int unsigned FLAG_CARRY_POS = 2;
  localparam int unsigned FLAG_SUPER_POS = 3;
  localparam int unsigned FLAG_BANK_POS = 4;

  // Bits that a logical instruction may write: bank, carry, zero and interrupt enable.
  localparam logic [7:0] FLAG_SW_MASK = 8'h17;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] FLAGS_RESET = 8'h02;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [15:0] PC_RESET = 16'h0000;

  // Length of a source-immediate instruction in program bytes.
  localparam logic [15:0] SRC_IMM_LEN = 16'h0002;

  // ----------------------------------------------------------------
  // Destination selects and ALU operations
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    DST_ACC = 2'b00,
    DST_FLAGS = 2'b01,
    DST_STACK = 2'b10,
    DST_INDEX = 2'b11
  } dest_sel_type;

  typedef enum logic [2:0] {
    OP_MOV = 3'b000,
    OP_ADD = 3'b001,
    OP_ADC = 3'b010,
    OP_SUB = 3'b011,
    OP_AND = 3'b100,
    OP_OR = 3'b101,
    OP_XOR = 3'b110,
    OP_CMP = 3'b111
  } alu_op_type;

  // Source-immediate instruction issued by the decoder.
  typedef struct packed {
    logic valid;
    dest_sel_type dest;
    alu_op_type op;
    logic [7:0] imm;
  } src_imm_cmd_type;

  // Stack pointer adjustment from push/pop/call/return, swap and add.
  typedef struct packed {
    logic inc;
    logic dec;
    logic inc2;
    logic dec2;
    logic load;
    logic [7:0] value;
  } stack_cmd_type;

  // Program counter sequencing.
  typedef struct packed {
    logic advance;
    logic load;
    logic [15:0] target;
  } pc_cmd_type;

  // Core-owned updates to flags (supervisory state, interrupt entry/return).
  typedef struct packed {
    logic super_set;
    logic super_clr;
    logic restore;
    logic [7:0] value;
  } core_flag_cmd_type;

  typedef struct packed {
    logic [7:0] flags;
    logic [7:0] acc;
    logic [7:0] index;
    logic [7:0] stack;
    logic [15:0] pc;
  } reg_view_type;

endpackage : core_regs_pkg

// file: imm_alu.sv
// Purpose: Combinational ALU for source-immediate instructions.
// Assumes: Operands are 8-bit; carry input comes from the flags register.
// Notes: Logical operations leave carry clear; compare produces flags only.
`timescale 1ns/1ns
module imm_alu (
  input wire core_regs_pkg::alu_op_type op_in, // Operation select.
  input wire logic [7:0] dst_in, // Current value of the destination.
  input wire logic [7:0] imm_in, // Immediate operand byte.
  input wire logic carry_in, // Carry flag for add with carry.
  output logic [7:0] result_out, // Operation result.
  output logic carry_out, // Carry or borrow.
  output logic zero_out, // Result is zero.
  output logic writes_out // Result is stored in the destination.
);

  logic [8:0] sum;

  always_comb begin
    sum = 9'h000;
    writes_out = 1'b1;
    unique case (op_in)
      core_regs_pkg::OP_MOV: sum = {1'b0, imm_in};
      core_regs_pkg::OP_ADD: sum = {1'b0, dst_in} + {1'b0, imm_in};
      core_regs_pkg::OP_ADC: sum = {1'b0, dst_in} + {1'b0, imm_in} + {8'h00, carry_in};
      core_regs_pkg::OP_SUB: sum = {1'b0, dst_in} - {1'b0, imm_in};
      core_regs_pkg::OP_AND: sum = {1'b0, dst_in & imm_in};
      core_regs_pkg::OP_OR: sum = {1'b0, dst_in | imm_in};
      core_regs_pkg::OP_XOR: sum = {1'b0, dst_in ^ imm_in};
      core_regs_pkg::OP_CMP: begin
        sum = {1'b0, dst_in} - {1'b0, imm_in};
        writes_out = 1'b0;
      end
    endcase
  end

  assign result_out = sum[7:0];
  assign carry_out = sum[8];
  assign zero_out = (sum[7:0] == 8'h00);

endmodule : imm_alu

// file: cpu_core_register_set.sv
// Purpose: Architectural register set of an 8-bit core: flags, A, X, SP and PC.
// Assumes: The decoder issues at most one source-immediate command per cycle.
// Notes: Registers are internal to the core and are not in the register space.
`timescale 1ns/1ns
module cpu_core_register_set (
  input wire logic clk_in, // Core clock, 250 MHz.
  input wire logic rst_b_in, // Synchronous reset, active low.
  input wire core_regs_pkg::src_imm_cmd_type imm_cmd_in, // Source-immediate command.
  input wire core_regs_pkg::stack_cmd_type stack_cmd_in, // Stack pointer command.
  input wire core_regs_pkg::pc_cmd_type pc_cmd_in, // Program counter command.
  input wire core_regs_pkg::core_flag_cmd_type flag_cmd_in, // Core-owned flag update.
  input wire logic acc_load_in, // Load accumulator from other source modes.
  input wire logic [7:0] acc_data_in, // Result for accumulator loads.
  input wire logic index_load_in, // Load index register from other source modes.
  input wire logic [7:0] index_data_in, // Result for index register loads.
  output core_regs_pkg::reg_view_type regs_out, // Current register contents.
  output logic [7:0] program_counter_high_out, // Program counter bits 15 to 8.
  output logic [7:0] program_counter_low_out, // Program counter bits 7 to 0.
  output logic [15:0] program_counter_full_out, // Program memory address.
  output logic register_bank_select_out, // Register space bank select.
  output logic interrupt_master_enable_out, // Global interrupt enable.
  output logic [7:0] index_out // Index for indexed addressing.
);

  logic [7:0] flags_ff;
  logic [7:0] acc_ff;
  logic [7:0] index_ff;
  logic [7:0] stack_ff;
  logic [7:0] pc_high_ff;
  logic [7:0] pc_low_ff;
  logic [7:0] alu_dst;
  logic [7:0] alu_result;
  logic alu_carry;
  logic alu_zero;
  logic alu_writes;
  logic imm_is_logical;
  logic [15:0] pc_now;
  logic [15:0] nxt_pc;
  logic [7:0] nxt_flags;
  logic [7:0] nxt_stack;

  // ----------------------------------------------------------------
  // Immediate operand path
  // ----------------------------------------------------------------
  always_comb begin
    unique case (imm_cmd_in.dest)
      core_regs_pkg::DST_ACC: alu_dst = acc_ff;
      core_regs_pkg::DST_FLAGS: alu_dst = flags_ff;
      core_regs_pkg::DST_STACK: alu_dst = stack_ff;
      core_regs_pkg::DST_INDEX: alu_dst = index_ff;
    endcase
  end

  // The immediate byte is the second source; the destination is the first.
  imm_alu alu_inst (
    .op_in(imm_cmd_in.op),
    .dst_in(alu_dst),
    .imm_in(imm_cmd_in.imm),
    .carry_in(flags_ff[core_regs_pkg::FLAG_CARRY_POS]),
    .result_out(alu_result),
    .carry_out(alu_carry),
    .zero_out(alu_zero),
    .writes_out(alu_writes)
  );

  // Only these three may write the flag byte; every other operation is refused there.
  assign imm_is_logical = (imm_cmd_in.op == core_regs_pkg::OP_AND) ||
                          (imm_cmd_in.op == core_regs_pkg::OP_OR) ||
                          (imm_cmd_in.op == core_regs_pkg::OP_XOR);

  // ----------------------------------------------------------------
  // Flags register
  // ----------------------------------------------------------------
  always_comb begin
    nxt_flags = flags_ff;
    if (imm_cmd_in.valid && (imm_cmd_in.dest == core_regs_pkg::DST_FLAGS)) begin
      // Only logical operations may write the flags directly.
      if (imm_is_logical) begin
        nxt_flags = (flags_ff & ~core_regs_pkg::FLAG_SW_MASK) |
                    (alu_result & core_regs_pkg::FLAG_SW_MASK);
      end
    end else if (imm_cmd_in.valid) begin
      // Arithmetic and logic results update carry and zero as side effects.
      nxt_flags[core_regs_pkg::FLAG_ZERO_POS] = alu_zero;
      nxt_flags[core_regs_pkg::FLAG_CARRY_POS] = alu_carry;
    end
    // A restore puts back a saved byte whole, so it overrides any software write
    // in the same cycle; the supervisory and reserved rules below still apply.
    if (flag_cmd_in.restore) begin
      nxt_flags = flag_cmd_in.value;
    end
    // Supervisory state is driven by the core alone.
    if (flag_cmd_in.super_set) begin
      nxt_flags[core_regs_pkg::FLAG_SUPER_POS] = 1'b1;
    end else if (flag_cmd_in.super_clr) begin
      nxt_flags[core_regs_pkg::FLAG_SUPER_POS] = 1'b0;
    end
    // Reserved bits always read as zero.
    nxt_flags[7:5] = 3'b000;
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      flags_ff <= core_regs_pkg::FLAGS_RESET;
    end else begin
      flags_ff <= nxt_flags;
    end
  end

  // ----------------------------------------------------------------
  // Accumulator and index register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      acc_ff <= core_regs_pkg::BYTE_RESET;
    end else if (imm_cmd_in.valid && alu_writes &&
                 (imm_cmd_in.dest == core_regs_pkg::DST_ACC)) begin
      // A compare never lands here, so it updates carry and zero only.
      acc_ff <= alu_result;
    end else if (acc_load_in) begin
      acc_ff <= acc_data_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      index_ff <= core_regs_pkg::BYTE_RESET;
    end else if (imm_cmd_in.valid && alu_writes &&
                 (imm_cmd_in.dest == core_regs_pkg::DST_INDEX)) begin
      index_ff <= alu_result;
    end else if (index_load_in) begin
      index_ff <= index_data_in;
    end
  end

  // ----------------------------------------------------------------
  // Stack pointer
  // ----------------------------------------------------------------
  always_comb begin
    nxt_stack = stack_ff;
    // An immediate write beats the stack commands; the decoder never issues both
    // for one instruction, so the order only settles a faulty decode.
    if (imm_cmd_in.valid && alu_writes &&
        (imm_cmd_in.dest == core_regs_pkg::DST_STACK)) begin
      nxt_stack = alu_result;
    end else if (stack_cmd_in.load) begin
      nxt_stack = stack_cmd_in.value;
    end else if (stack_cmd_in.inc2) begin
      nxt_stack = stack_ff + 8'h02;
    end else if (stack_cmd_in.dec2) begin
      nxt_stack = stack_ff - 8'h02;
    end else if (stack_cmd_in.inc) begin
      nxt_stack = stack_ff + 8'h01;
    end else if (stack_cmd_in.dec) begin
      nxt_stack = stack_ff - 8'h01;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      stack_ff <= core_regs_pkg::BYTE_RESET;
    end else begin
      stack_ff <= nxt_stack;
    end
  end

  // ----------------------------------------------------------------
  // Program counter
  // ----------------------------------------------------------------
  assign pc_now = {pc_high_ff, pc_low_ff};

  always_comb begin
    nxt_pc = pc_now;
    // A jump beats the step so a taken branch never lands two bytes late.
    if (pc_cmd_in.load) begin
      nxt_pc = pc_cmd_in.target;
    end else if (imm_cmd_in.valid) begin
      // A source-immediate instruction spans opcode plus one operand.
      nxt_pc = pc_now + core_regs_pkg::SRC_IMM_LEN;
    end else if (pc_cmd_in.advance) begin
      nxt_pc = pc_now + 16'h0001;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      pc_high_ff <= core_regs_pkg::PC_RESET[15:8];
      pc_low_ff <= core_regs_pkg::PC_RESET[7:0];
    end else begin
      pc_high_ff <= nxt_pc[15:8];
      pc_low_ff <= nxt_pc[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign program_counter_high_out = pc_high_ff;
  assign program_counter_low_out = pc_low_ff;
  assign program_counter_full_out = pc_now;
  // Bank 0 is selected while the bit is clear and bank 1 while it is set.
  assign register_bank_select_out = flags_ff[core_regs_pkg::FLAG_BANK_POS];
  assign interrupt_master_enable_out = flags_ff[core_regs_pkg::FLAG_IE_POS];
  assign index_out = index_ff;
  assign regs_out = '{flags: flags_ff, acc: acc_ff, index: index_ff, stack: stack_ff,
                      pc: pc_now};

endmodule : cpu_core_register_set

// file: core_regs_checker.sv
// Purpose: Port-level assertions for the core register set.
// Assumes: One core clock and a synchronous active-low reset.
// Notes: Bound to every instance; it watches only the block's ports, never its internal registers.
`timescale 1ns/1ns
module core_regs_checker (
  input wire logic clk_in, // Core clock.
  input wire logic rst_b_in, // Reset, active low.
  input wire core_regs_pkg::src_imm_cmd_type imm_cmd_in, // Immediate command.
  input wire core_regs_pkg::stack_cmd_type stack_cmd_in, // Stack command.
  input wire core_regs_pkg::pc_cmd_type pc_cmd_in, // Program counter command.
  input wire core_regs_pkg::core_flag_cmd_type flag_cmd_in, // Core flag update.
  input wire core_regs_pkg::reg_view_type regs_out, // Register view.
  input wire logic [7:0] program_counter_high_out, // Counter high byte.
  input wire logic [7:0] program_counter_low_out, // Counter low byte.
  input wire logic [15:0] program_counter_full_out, // Counter word.
  input wire logic register_bank_select_out, // Bank select.
  input wire logic interrupt_master_enable_out, // Interrupt enable.
  input wire logic [7:0] index_out // Index value.
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  sequence s_mov_acc;
    imm_cmd_in.valid && imm_cmd_in.dest == core_regs_pkg::DST_ACC &&
      imm_cmd_in.op == core_regs_pkg::OP_MOV;
  endsequence
  sequence s_flag_refused;
    imm_cmd_in.valid && imm_cmd_in.dest == core_regs_pkg::DST_FLAGS &&
      imm_cmd_in.op != core_regs_pkg::OP_AND && imm_cmd_in.op != core_regs_pkg::OP_OR &&
      imm_cmd_in.op != core_regs_pkg::OP_XOR && flag_cmd_in == '0;
  endsequence
  property p_flag_refuse;
    s_flag_refused |=> $stable(regs_out.flags);
  endproperty
  property p_reset;
    disable iff (1'b0) !rst_b_in |=> regs_out == {core_regs_pkg::FLAGS_RESET, 40'h0};
  endproperty
  property p_pc_split;
    program_counter_full_out == {program_counter_high_out, program_counter_low_out};
  endproperty
  property p_imm_pc;
    imm_cmd_in.valid && !pc_cmd_in.load |=>
      program_counter_full_out == $past(program_counter_full_out) + 16'h0002;
  endproperty
  property p_flag_hold;
    !imm_cmd_in.valid && flag_cmd_in == '0 |=> $stable(regs_out.flags);
  endproperty
  property p_super;
    flag_cmd_in == '0 |=> regs_out.flags[3] == $past(regs_out.flags[3]);
  endproperty
  property p_reserved;
    regs_out.flags[7:5] == 3'h0;
  endproperty
  property p_views;
    register_bank_select_out == regs_out.flags[4] &&
      interrupt_master_enable_out == regs_out.flags[0] && index_out == regs_out.index;
  endproperty
  property p_mov_acc;
    s_mov_acc |=> regs_out.acc == $past(imm_cmd_in.imm);
  endproperty
  property p_stack_inc;
    !imm_cmd_in.valid && stack_cmd_in.inc && !stack_cmd_in.inc2 && !stack_cmd_in.dec2 &&
      !stack_cmd_in.load |=> regs_out.stack == $past(regs_out.stack) + 8'h01;
  endproperty
  a_reset: assert property (p_reset) else $error("reset values wrong");
  a_pc_split: assert property (p_pc_split) else $error("counter bytes disagree");
  a_imm_pc: assert property (p_imm_pc) else $error("counter did not step by two");
  a_flag_hold: assert property (p_flag_hold) else $error("flags changed alone");
  a_super: assert property (p_super) else $error("supervisory bit changed");
  a_reserved: assert property (p_reserved) else $error("reserved flag bits set");
  a_views: assert property (p_views) else $error("flag or index view wrong");
  a_mov_acc: assert property (p_mov_acc) else $error("immediate not in acc");
  a_stack_inc: assert property (p_stack_inc) else $error("stack did not step");
  a_flag_refuse: assert property (p_flag_refuse) else $error("non-logical flag write");
endmodule : core_regs_checker

bind cpu_core_register_set core_regs_checker u_chk (.clk_in(clk_in), .rst_b_in(rst_b_in),
  .imm_cmd_in(imm_cmd_in), .stack_cmd_in(stack_cmd_in), .pc_cmd_in(pc_cmd_in),
  .flag_cmd_in(flag_cmd_in), .regs_out(regs_out),
  .program_counter_high_out(program_counter_high_out),
  .program_counter_low_out(program_counter_low_out),
  .program_counter_full_out(program_counter_full_out),
  .register_bank_select_out(register_bank_select_out),
  .interrupt_master_enable_out(interrupt_master_enable_out), .index_out(index_out));

// file: testbench.sv
// Purpose: Self-checking bench for the core register set.
// Assumes: Inputs change on the falling edge; results show one edge later.
// Notes: Expected values are worked out here, never read back from the block.
`timescale 1ns/1ns
module testbench;
  logic clk_in;
  logic rst_b_in;
  core_regs_pkg::src_imm_cmd_type imm_cmd_in;
  core_regs_pkg::stack_cmd_type stack_cmd_in;
  core_regs_pkg::pc_cmd_type pc_cmd_in;
  core_regs_pkg::core_flag_cmd_type flag_cmd_in;
  logic acc_load_in;
  logic [7:0] acc_data_in;
  logic index_load_in;
  logic [7:0] index_data_in;
  core_regs_pkg::reg_view_type regs;
  logic [7:0] pch;
  logic [7:0] pcl;
  logic [15:0] pcf;
  logic bank;
  logic ie;
  logic [7:0] idx;
  logic [15:0] exp_pc;
  int error_cnt;
  int checks_done;
  cpu_core_register_set DUT (.clk_in(clk_in), .rst_b_in(rst_b_in), .imm_cmd_in(imm_cmd_in),
    .stack_cmd_in(stack_cmd_in), .pc_cmd_in(pc_cmd_in), .flag_cmd_in(flag_cmd_in),
    .acc_load_in(acc_load_in), .acc_data_in(acc_data_in), .index_load_in(index_load_in),
    .index_data_in(index_data_in), .regs_out(regs), .program_counter_high_out(pch),
    .program_counter_low_out(pcl), .program_counter_full_out(pcf),
    .register_bank_select_out(bank), .interrupt_master_enable_out(ie), .index_out(idx));
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic cmp(input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: expected %h got %h", $time, exp, got);
    end
  endtask : cmp
  // The command stays valid on return, so back-to-back calls never drop and raise
  // it in one step; a scenario clears it itself before any idle cycle.
  task automatic imm(input logic [1:0] d, input logic [2:0] o, input logic [7:0] v);
    imm_cmd_in = {1'b1, d, o, v};
    exp_pc = exp_pc + 16'h0002;
    @(negedge clk_in);
  endtask : imm
  task automatic complete_run;
    $display("checks_done=%0d error_cnt=%0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : complete_run
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_acc;
    imm(2'h0, 3'h0, 8'h01);
    imm(2'h0, 3'h1, 8'h07);
    cmp(16'h0008, regs.acc);
    imm(2'h0, 3'h1, 8'hff);
    cmp(16'h0207, {6'h0, regs.flags[2:1], regs.acc});
    cmp(exp_pc, {pch, pcl});
    imm_cmd_in = '0;
    acc_load_in = 1'b1;
    acc_data_in = 8'h5a;
    @(negedge clk_in);
    acc_load_in = 1'b0;
    imm(2'h0, 3'h7, 8'h5a);
    cmp(16'h015a, {7'h0, regs.flags[1], regs.acc});
    imm(2'h0, 3'h3, 8'h5b);
    imm(2'h0, 3'h2, 8'h00);
    cmp(16'h0300, {6'h0, regs.flags[2:1], regs.acc});
    $display("test_acc done");
  endtask : test_acc
  task automatic test_flags;
    logic [7:0] vals [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h05, 8'h10, 8'h15, 8'h00};
    logic [7:0] exps [8] = '{8'h17, 8'h17, 8'h17, 8'h17, 8'h05, 8'h15, 8'h00, 8'h00};
    imm(2'h1, 3'h5, 8'hff);
    cmp(16'h0317, {6'h0, bank, ie, regs.flags});
    for (int i = 0; i < 8; i++) begin
      imm(2'h1, i[2:0], vals[i]);
      cmp(exps[i], regs.flags);
    end
    imm_cmd_in = '0;
    flag_cmd_in.super_set = 1'b1;
    @(negedge clk_in);
    flag_cmd_in = '0;
    imm(2'h1, 3'h5, 8'hff);
    cmp(16'h001f, regs.flags);
    imm(2'h1, 3'h4, 8'h00);
    cmp(16'h0008, regs.flags);
    imm_cmd_in = '0;
    flag_cmd_in = {1'b0, 1'b1, 1'b1, 8'hff};
    @(negedge clk_in);
    flag_cmd_in = '0;
    cmp(16'h0017, regs.flags);
    $display("test_flags done");
  endtask : test_flags
  task automatic test_stack;
    logic [12:0] cmds [5] = '{13'h1000, 13'h0400, 13'h0800, 13'h0200, 13'h0180};
    logic [7:0] exps [5] = '{8'h41, 8'h43, 8'h42, 8'h40, 8'h80};
    imm(2'h2, 3'h0, 8'h40);
    cmp(16'h0040, regs.stack);
    imm_cmd_in = '0;
    for (int i = 0; i < 5; i++) begin
      stack_cmd_in = cmds[i];
      @(negedge clk_in);
      cmp(exps[i], regs.stack);
    end
    stack_cmd_in = 13'h1000;
    imm(2'h2, 3'h0, 8'h11);
    stack_cmd_in = '0;
    cmp(16'h0011, regs.stack);
    imm(2'h3, 3'h0, 8'h33);
    cmp(16'h3333, {idx, regs.index});
    imm_cmd_in = '0;
    index_load_in = 1'b1;
    index_data_in = 8'h5c;
    @(negedge clk_in);
    index_load_in = 1'b0;
    cmp(16'h005c, idx);
    $display("test_stack done");
  endtask : test_stack
  task automatic test_pc;
    pc_cmd_in = {1'b0, 1'b1, 16'h1ffe};
    @(negedge clk_in);
    pc_cmd_in = {1'b1, 1'b0, 16'h0000};
    @(negedge clk_in);
    pc_cmd_in = '0;
    cmp(16'h1fff, pcf);
    exp_pc = 16'h1fff;
    imm(2'h0, 3'h0, 8'h00);
    cmp(exp_pc, {pch, pcl});
    pc_cmd_in = {1'b0, 1'b1, 16'h0100};
    imm(2'h0, 3'h0, 8'h00);
    pc_cmd_in = '0;
    cmp(16'h0100, regs.pc);
    imm_cmd_in = '0;
    $display("test_pc done");
  endtask : test_pc
  initial begin
    repeat (10000) @(posedge clk_in);
    error_cnt++;
    complete_run;
  end
  initial begin
    rst_b_in = 1'b0;
    {imm_cmd_in, stack_cmd_in, pc_cmd_in, flag_cmd_in} = '0;
    {acc_load_in, acc_data_in, index_load_in, index_data_in} = '0;
    exp_pc = 16'h0000;
    error_cnt = 0;
    checks_done = 0;
    repeat (5) @(negedge clk_in);
    rst_b_in = 1'b1;
    cmp(16'h0200, regs[47:32]);
    cmp(16'h0000, regs[31:16] | regs[15:0] | {14'h0, bank, ie});
    test_acc;
    test_flags;
    test_stack;
    test_pc;
    complete_run;
  end
endmodule : testbench
